// ==== rpc_poll_ctrl.sv ====
// Purpose: Polling controller with edge-to-edge bit check
// Assumes: Mode and demodulator pins are asynchronous
// Notes: Registers reached over APB, answer without wait
`timescale 1ns/10ps
`include "rpc_defs.svh"

// What this block does
// R01 - Basic clock divided per clock-select pin
// R02 - Extended clock is 8,4,2,1 basic periods
// R03 - Cycle sleep, start-up, check; sleep disables
// R04 - Start-up enables circuits and lets settle
// R05 - Demodulator ignored until bit check active
// R06 - No valid signal: back to sleep
// R07 - Activity output separates sleep from active
// R08 - Sleep = value x factor x 1024 x period
// R09 - Sleep factor 1, or 8 with bit
// R10 - Highest sleep value means permanent sleep
// R11 - Bit count 0,3,6,9 gives 0,6,12,18 checks
// R12 - All checks pass: receive, route data out
// R13 - Counter on extended clock, sampled at edges
// R14 - Two 5-bit limits scale extended period
// R15 - Edge below lower limit fails to sleep
// R16 - Counter reaching upper limit fails at once
// R17 - Software keeps lower >= 10, upper <= 63
// R18 - Lower below 19: use 6 or 9 bits
// R19 - Window about 25% around expected time
// R20 - Preburst covers sleep, start-up, check, MCU
// R21 - Receive held until polling command
// R22 - Counter cleared at every accepted edge
module rpc_poll_ctrl #(
    parameter int SLEEP_UNIT = `RPC_SLEEP_UNIT,
    parameter int STARTUP_TICKS = `RPC_STARTUP_TICKS
) (
    input wire logic clk_i, // 50 MHz clock
    input wire logic rst_n_i, // Sync reset, active low
    input wire rpc_pkg::rpc_apb_req_t apb_req_i, // APB request
    output rpc_pkg::rpc_apb_rsp_t apb_rsp_o, // APB answer
    input wire logic clock_select_i, // Mode pin, async
    input wire logic demod_i, // Demodulator output, async
    output logic activity_indicator_o, // High when active
    output logic data_o // Data out, high unless receiving
);
    import rpc_pkg::*;

    // ------------------------------------------------------
    // Helpers
    // ------------------------------------------------------
    function automatic logic [3:0] xlen(input logic [1:0] br);
        xlen = 4'h8 >> br;
    endfunction : xlen

    function automatic logic [23:0] sleep_len(
        input logic [4:0] s,
        input logic ext
    );
        logic [23:0] f;
        f = ext ? 24'(`RPC_SLEEP_EXT_X) : 24'h000001; // [R09]
        sleep_len = 24'(s) * f * 24'(SLEEP_UNIT); // [R08]
    endfunction : sleep_len

    // ------------------------------------------------------
    // State
    // ------------------------------------------------------
    logic [1:0] baud, next_baud;
    logic [1:0] nbit, next_nbit;
    logic [4:0] sleep_val, next_sleep_val;
    logic sleep_ext, next_sleep_ext;
    logic [4:0] lim_min, next_lim_min;
    logic [4:0] lim_max, next_lim_max;
    logic [31:0] prdata, next_prdata;
    logic mode_s1, mode_s2, dem_s1, dem_s2, dem_s3;
    logic [6:0] div_cnt, next_div_cnt;
    logic [2:0] xdiv, next_xdiv;
    rpc_phase_t phase, next_phase;
    logic [23:0] sleep_cnt, next_sleep_cnt;
    logic [7:0] su_cnt, next_su_cnt;
    logic [5:0] cv, next_cv;
    logic [4:0] pass_cnt, next_pass_cnt;
    logic active, next_active;
    logic data_q, next_data_q;

    logic acc, wr, mapped, cfg_wr, poll_cmd;
    logic tick, xtick, dem_edge;
    logic [6:0] div_lim;

    // ------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
            dem_s1 <= 1'b1;
            dem_s2 <= 1'b1;
            dem_s3 <= 1'b1;
        end else begin
            mode_s1 <= clock_select_i;
            mode_s2 <= mode_s1;
            dem_s1 <= demod_i;
            dem_s2 <= dem_s1;
            dem_s3 <= dem_s2;
        end
    end

    assign dem_edge = dem_s2 ^ dem_s3;

    // ------------------------------------------------------
    // APB slave
    // ------------------------------------------------------
    assign acc = apb_req_i.psel & apb_req_i.penable;
    assign wr = acc & apb_req_i.pwrite;
    assign mapped = (apb_req_i.paddr == `RPC_OFS_CFG) ||
                    (apb_req_i.paddr == `RPC_OFS_LIMIT) ||
                    (apb_req_i.paddr == `RPC_OFS_CTRL) ||
                    (apb_req_i.paddr == `RPC_OFS_STATUS);
    assign cfg_wr = wr & (apb_req_i.paddr == `RPC_OFS_CFG);
    assign poll_cmd = wr & (apb_req_i.paddr == `RPC_OFS_CTRL) &
                      apb_req_i.pwdata[`RPC_CTRL_POLL];

    always_comb begin
        next_baud = baud;
        next_nbit = nbit;
        next_sleep_val = sleep_val;
        next_sleep_ext = sleep_ext;
        next_lim_min = lim_min;
        next_lim_max = lim_max;
        next_prdata = prdata;
        if (cfg_wr) begin
            next_baud = apb_req_i.pwdata[`RPC_CFG_BAUD];
            next_nbit = apb_req_i.pwdata[`RPC_CFG_NBIT]; // [R11]
            next_sleep_val = apb_req_i.pwdata[`RPC_CFG_SLEEP];
            next_sleep_ext = apb_req_i.pwdata[`RPC_CFG_SLEEP_EXT];
        end
        if (wr && apb_req_i.paddr == `RPC_OFS_LIMIT) begin
            next_lim_min = apb_req_i.pwdata[`RPC_LIM_MIN]; // [R14]
            next_lim_max = apb_req_i.pwdata[`RPC_LIM_MAX]; // [R14]
        end
        // Read data is captured in the setup cycle
        if (apb_req_i.psel && !apb_req_i.penable) begin
            next_prdata = 32'h00000000;
            unique case (apb_req_i.paddr)
                `RPC_OFS_CFG: begin
                    next_prdata[`RPC_CFG_BAUD] = baud;
                    next_prdata[`RPC_CFG_NBIT] = nbit;
                    next_prdata[`RPC_CFG_SLEEP] = sleep_val;
                    next_prdata[`RPC_CFG_SLEEP_EXT] = sleep_ext;
                end
                `RPC_OFS_LIMIT: begin
                    next_prdata[`RPC_LIM_MIN] = lim_min;
                    next_prdata[`RPC_LIM_MAX] = lim_max;
                end
                `RPC_OFS_STATUS: begin
                    next_prdata[1:0] = phase;
                    next_prdata[2] = active;
                    next_prdata[12:8] = pass_cnt;
                end
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            baud <= `RPC_RST_BAUD;
            nbit <= `RPC_RST_NBIT;
            sleep_val <= `RPC_RST_SLEEP;
            sleep_ext <= 1'b0;
            lim_min <= `RPC_RST_LIM_MIN;
            lim_max <= `RPC_RST_LIM_MAX;
            prdata <= 32'h00000000;
        end else begin
            baud <= next_baud;
            nbit <= next_nbit;
            sleep_val <= next_sleep_val;
            sleep_ext <= next_sleep_ext;
            lim_min <= next_lim_min;
            lim_max <= next_lim_max;
            prdata <= next_prdata;
        end
    end

    assign apb_rsp_o.prdata = prdata;
    assign apb_rsp_o.pready = 1'b1;
    // Unmapped accesses complete at once but flag an error
    assign apb_rsp_o.pslverr = acc & ~mapped;

    // ------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------
    // Basic period is truncated to whole system clocks
    assign div_lim = mode_s2 ? 7'(`RPC_TCLK_H_CYC) :
                               7'(`RPC_TCLK_L_CYC); // [R01]
    assign tick = (div_cnt == div_lim - 7'h01); // [R01]
    assign xtick = tick &&
        ({1'b0, xdiv} == xlen(baud) - 4'h1); // [R02]

    // ------------------------------------------------------
    // Polling sequence
    // ------------------------------------------------------

    always_comb begin
        next_div_cnt = tick ? 7'h00 : div_cnt + 7'h01;
        next_xdiv = 3'h0;
        next_phase = phase;
        next_sleep_cnt = sleep_cnt;
        next_su_cnt = su_cnt;
        next_cv = cv;
        next_pass_cnt = pass_cnt;
        unique case (phase)
            PH_SLEEP: begin
                // A config write restarts the sleep count
                if (cfg_wr) begin
                    next_sleep_cnt = 24'h000000;
                end else if (sleep_val != `RPC_SLEEP_HOLD) begin // [R10]
                    if (sleep_cnt >= sleep_len(sleep_val, sleep_ext)) begin
                        next_phase = PH_STARTUP; // [R03]
                        next_su_cnt = 8'h00;
                    end else if (tick) begin
                        next_sleep_cnt = sleep_cnt + 24'h000001; // [R08]
                    end
                end
            end
            PH_STARTUP: begin
                // Demodulator edges are not looked at here
                if (su_cnt >= 8'(STARTUP_TICKS)) begin // [R04] [R05]
                    next_phase = PH_CHECK;
                    next_cv = 6'h00;
                    next_pass_cnt = 5'h00;
                end else if (tick) begin
                    next_su_cnt = su_cnt + 8'h01;
                end
            end
            PH_CHECK: begin
                if (tick) begin
                    next_xdiv = xtick ? 3'h0 : xdiv + 3'h1; // [R02]
                end else begin
                    next_xdiv = xdiv;
                end
                if (nbit == 2'h0) begin
                    next_phase = PH_RECEIVE; // [R11]
                end else if (cv >= {1'b0, lim_max}) begin
                    next_phase = PH_SLEEP; // [R16] [R06]
                    next_sleep_cnt = 24'h000000;
                end else if (dem_edge) begin // [R13]
                    if (cv < {1'b0, lim_min}) begin
                        next_phase = PH_SLEEP; // [R15] [R06]
                        next_sleep_cnt = 24'h000000;
                    end else begin
                        next_cv = 6'h00; // [R22]
                        next_pass_cnt = pass_cnt + 5'h01;
                        if (next_pass_cnt == 5'(nbit *
                                `RPC_CHECKS_PER_STEP)) begin
                            next_phase = PH_RECEIVE; // [R11] [R12]
                        end
                    end
                end else if (xtick) begin
                    next_cv = cv + 6'h01; // [R13]
                end
            end
            PH_RECEIVE: begin
                if (poll_cmd) begin
                    next_phase = PH_SLEEP; // [R21]
                    next_sleep_cnt = 24'h000000;
                end
            end
        endcase
        next_active = (next_phase != PH_SLEEP); // [R07] [R03]
        // Follows the next phase so data is high again with sleep
        next_data_q = (next_phase == PH_RECEIVE) ? dem_s2 : 1'b1; // [R12]
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_cnt <= 7'h00;
            xdiv <= 3'h0;
            phase <= PH_SLEEP;
            sleep_cnt <= 24'h000000;
            su_cnt <= 8'h00;
            cv <= 6'h00;
            pass_cnt <= 5'h00;
            active <= 1'b0;
            data_q <= 1'b1;
        end else begin
            div_cnt <= next_div_cnt;
            xdiv <= next_xdiv;
            phase <= next_phase;
            sleep_cnt <= next_sleep_cnt;
            su_cnt <= next_su_cnt;
            cv <= next_cv;
            pass_cnt <= next_pass_cnt;
            active <= next_active;
            data_q <= next_data_q;
        end
    end

    // ------------------------------------------------------
    // Outputs
    // ------------------------------------------------------

    assign activity_indicator_o = active;
    assign data_o = data_q;

endmodule : rpc_poll_ctrl

// ==== rpc_defs.svh ====
// Purpose: Constants of the receiver polling controller
// Assumes: 50 MHz system clock, byte addresses on APB
// Notes: Offsets, fields, reset values and timing counts
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH

// ----------------------------------------------------------
// Register map
// ----------------------------------------------------------
`define RPC_OFS_CFG 8'h00
`define RPC_OFS_LIMIT 8'h04
`define RPC_OFS_CTRL 8'h08
`define RPC_OFS_STATUS 8'h0c

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define RPC_CFG_BAUD 1:0
`define RPC_CFG_NBIT 3:2
`define RPC_CFG_SLEEP 8:4
`define RPC_CFG_SLEEP_EXT 9
`define RPC_LIM_MIN 4:0
`define RPC_LIM_MAX 12:8
`define RPC_CTRL_POLL 0

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define RPC_RST_BAUD 2'h0
`define RPC_RST_NBIT 2'h1
`define RPC_RST_SLEEP 5'h08
`define RPC_RST_LIM_MIN 5'h0e
`define RPC_RST_LIM_MAX 5'h18
`define RPC_SLEEP_HOLD 5'h1f

// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define RPC_SYS_PERIOD_PS 20000
`define RPC_TCLK_L_PS 2038300
`define RPC_TCLK_H_PS 2069700
`define RPC_TCLK_L_CYC (`RPC_TCLK_L_PS / `RPC_SYS_PERIOD_PS)
`define RPC_TCLK_H_CYC (`RPC_TCLK_H_PS / `RPC_SYS_PERIOD_PS)
`define RPC_SLEEP_UNIT 1024
`define RPC_SLEEP_EXT_X 8
`define RPC_STARTUP_TICKS 64
`define RPC_CHECKS_PER_STEP 6

`endif

// ==== rpc_pkg.sv ====
// Purpose: Types of the receiver polling controller
// Assumes: APB with 32-bit data
// Notes: Constants live in rpc_defs.svh
package rpc_pkg;

    typedef enum logic [1:0] {
        PH_SLEEP,
        PH_STARTUP,
        PH_CHECK,
        PH_RECEIVE
    } rpc_phase_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rpc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rpc_apb_rsp_t;

endpackage : rpc_pkg

// ==== rpc_tx_model.sv ====
// Purpose: Remote transmitter sending a preburst
// Assumes: Edge spacing is given in clock cycles
// Notes: Holds its last level once the burst ends
`timescale 1ns/10ps
module rpc_tx_model (
    input wire logic clk_i, // Bench clock
    input wire logic go_i, // Start a burst
    input wire logic [15:0] gap_i, // Cycles per edge
    input wire logic [7:0] num_i, // Edges to send
    output logic demod_o // Demodulated level
);
    int cnt = 0;
    int left = 0;
    initial demod_o = 1'b1;
    always @(posedge clk_i) begin
        if (go_i) begin
            cnt <= 0;
            left <= int'(num_i);
        end else if (left > 0) begin
            if (cnt == int'(gap_i) - 1) begin
                cnt <= 0;
                left <= left - 1;
                demod_o <= ~demod_o;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : rpc_tx_model

// ==== rpc_poll_ctrl_monitor.sv ====
// Purpose: Port checker for the polling controller
// Assumes: Basic tick of at least 101 clocks
// Notes: Attached by bind below
`timescale 1ns/10ps
module rpc_mon #(
    parameter int STARTUP_TICKS = 4
) (
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire rpc_pkg::rpc_apb_req_t apb_req_i, // Request
    input wire rpc_pkg::rpc_apb_rsp_t apb_rsp_o, // Answer
    input wire logic clock_select_i, // Mode pin
    input wire logic demod_i, // Demodulator
    input wire logic activity_indicator_o, // Active
    input wire logic data_o // Data out
);
    import rpc_pkg::*;
    localparam int MIN_HI = (STARTUP_TICKS - 1) * 101;
    logic [31:0] hcnt;
    logic [31:0] next_hcnt;
    logic acc;
    logic bad;
    assign acc = apb_req_i.psel && apb_req_i.penable;
    assign bad = apb_req_i.paddr > 8'h0c || apb_req_i.paddr[1:0] != 2'h0;
    always_comb begin
        next_hcnt = activity_indicator_o ? hcnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_i) begin
        hcnt <= rst_n_i ? next_hcnt : 32'h0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_stat;
        acc && !apb_req_i.pwrite && apb_req_i.paddr == 8'h0c;
    endsequence
    a_err_unmapped: assert property (acc && bad |-> apb_rsp_o.pslverr)
        else $error("no error on unmapped access");
    a_ok_mapped: assert property (acc && !bad |-> !apb_rsp_o.pslverr)
        else $error("error on mapped access");
    a_rdata_hold: assert property ($changed(apb_rsp_o.prdata)
        |-> $past(apb_req_i.psel && !apb_req_i.penable))
        else $error("read data moved outside setup");
    a_stat_active: assert property (
        s_stat |-> apb_rsp_o.prdata[2] == $past(activity_indicator_o))
        else $error("status active bit wrong");
    a_stat_phase: assert property (
        s_stat |-> (apb_rsp_o.prdata[1:0] != 2'h0) == apb_rsp_o.prdata[2])
        else $error("phase and active disagree");
    a_sleep_data: assert property (!activity_indicator_o |-> data_o)
        else $error("data low while asleep");
    a_startup_min: assert property (
        $fell(activity_indicator_o) |-> hcnt >= 32'(MIN_HI))
        else $error("active phase shorter than start-up");
    a_rx_stay: assert property (
        !data_o && !acc && !$past(acc) |=> activity_indicator_o)
        else $error("receive left without command");
endmodule : rpc_mon
bind rpc_poll_ctrl rpc_mon #(.STARTUP_TICKS(STARTUP_TICKS)) u_mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .clock_select_i(clock_select_i),
    .demod_i(demod_i), .activity_indicator_o(activity_indicator_o),
    .data_o(data_o));

// ==== test_rpc_poll_ctrl.sv ====
// Purpose: Self-checking bench for the polling controller
// Assumes: Sleep unit and start-up cut to 4 ticks
// Notes: Expected times come from integer formulas
`timescale 1ns/10ps
module test_rpc_poll_ctrl;
    import rpc_pkg::*;
    localparam int SU = 4;
    localparam int ST = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs = 1'b0;
    logic go = 1'b0;
    logic [15:0] gap = 16'h0;
    logic [7:0] num = 8'h0;
    logic demod;
    logic act;
    logic dout;
    rpc_apb_req_t req = '0;
    rpc_apb_rsp_t rsp;
    logic [31:0] seed = 32'h7;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int b = 101;
    int n;
    int t;
    always #10 clk = ~clk;
    rpc_poll_ctrl #(.SLEEP_UNIT(SU), .STARTUP_TICKS(ST)) DUT (
        .clk_i(clk), .rst_n_i(rst_n), .apb_req_i(req),
        .apb_rsp_o(rsp), .clock_select_i(cs), .demod_i(demod),
        .activity_indicator_o(act), .data_o(dout));
    rpc_tx_model u_tx (.clk_i(clk), .go_i(go), .gap_i(gap),
        .num_i(num), .demod_o(demod));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic print_verdict;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic near(input int got, input int want, input int tol);
        chk(32'(got >= want - tol && got <= want + tol), 32'h1);
    endtask : near
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic wact(input logic v);
        n = 0;
        while (act !== v) begin
            @(posedge clk);
            n++;
        end
    endtask : wact
    task automatic burst(input int g, input int k);
        gap <= 16'(g);
        num <= 8'(k);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : burst
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 110000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h84);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h04, 32'h0a0a);
        for (int i = 0; i < 4; i++) begin
            wact(1'b0);
            apb(1'b1, 8'h00, 32'h14 | 32'(i));
            wact(1'b1);
            near(n, SU * b, b + 9);
            wact(1'b0);
            near(n, (ST + 10 * (8 >> i)) * b, ((8 >> i) + 1) * b + 9);
        end
        cs <= 1'b1;
        b = 103;
        wact(1'b0);
        apb(1'b1, 8'h00, 32'h227);
        wact(1'b1);
        near(n, 2 * 8 * SU * b, b + 9);
        apb(1'b1, 8'h04, 32'h180a);
        wact(1'b0);
        apb(1'b1, 8'h00, 32'h17);
        wact(1'b1);
        burst(2 * b, 5);
        wact(1'b0);
        near(n, (ST + 1) * b, 2 * b);
        apb(1'b1, 8'h04, 32'h0f0a);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            t = 11 + int'(seed[0]);
            wact(1'b0);
            apb(1'b1, 8'h00, 32'h13 | 32'(i) << 2);
            wact(1'b1);
            repeat ((ST + 1) * b) @(posedge clk);
            burst(t * b, 6 * i - int'(i == 1));
            repeat ((6 * i + 1) * t * b) @(posedge clk);
            apb(1'b0, 8'h0c, 32'h0);
            chk(32'(rd[1:0] == 2'h3), 32'(i != 1));
            if (i != 1) begin
                chk(32'(dout), 32'(demod));
                apb(1'b1, 8'h08, 32'h1);
                wact(1'b0);
                chk(32'(n < 3), 32'h1);
            end
        end
        wact(1'b0);
        apb(1'b1, 8'h00, 32'h1f7);
        n = 0;
        repeat (13000) begin
            @(posedge clk);
            n += int'(act);
        end
        chk(32'(n), 32'h0);
        apb(1'b1, 8'h00, 32'h1b);
        wact(1'b1);
        near(n, SU * b, b + 9);
        print_verdict;
    end
endmodule : test_rpc_poll_ctrl
